// ==== logic/vemr_map.vh ====
// Register map and field layout for the video encoder mode registers.
// Assumes a 5-bit subaddress and 8-bit register data.
`ifndef VEMR_MAP_VH
`define VEMR_MAP_VH
`define VEMR_ADDR_STD_FILT 5'h00
`define VEMR_ADDR_DAC_PWR 5'h01
`define VEMR_ADDR_ROUTING 5'h02
`define VEMR_RST_STD_FILT 8'h00
`define VEMR_RST_DAC_PWR 8'h00
`define VEMR_RST_ROUTING 8'h00
`define VEMR_RST_DAC_EN 6'h3f
`define VEMR_STD_LSB 0
`define VEMR_LUMA_LSB 2
`define VEMR_CHROMA_LSB 5
`define VEMR_LOW_POWER_BIT 6
`define VEMR_RSVD_ZERO_BIT 7
`define VEMR_PD_LSB 0
`define VEMR_COLOUR_SPACE_BIT 0
`define VEMR_LARGE_DAC_BIT 1
`define VEMR_DAC_SWITCH_BIT 2
`define VEMR_PEDESTAL_BIT 3
`define VEMR_DAC_PWR_MASK 8'h7f
`define VEMR_STD_NTSC 2'h0
`define VEMR_STD_PAL_BDGHI 2'h1
`define VEMR_STD_PAL_M 2'h2
`define VEMR_STD_PAL_N 2'h3
`define VEMR_SIG_CVBS 4'h0
`define VEMR_SIG_LUMA 4'h1
`define VEMR_SIG_CHROMA 4'h2
`define VEMR_SIG_R 4'h3
`define VEMR_SIG_G 4'h4
`define VEMR_SIG_B 4'h5
`define VEMR_SIG_Y 4'h6
`define VEMR_SIG_U 4'h7
`define VEMR_SIG_V 4'h8
`endif

// ==== logic/vemr_route.v ====
// DAC routing matrix: maps the routing bits to a source per DAC.
// Assumes registered inputs; output is combinational.
`timescale 1ns/1ps
`include "vemr_map.vh"
module vemr_route (
	input wire colour_space_bit,
	input wire large_dac_select_bit,
	input wire dac_switching_bit,
	output reg [23:0] dac_src
);
	reg [3:0] c0;
	reg [3:0] c1;
	reg [3:0] c2;
	always @*
	begin
		c0 = colour_space_bit ? `VEMR_SIG_Y : `VEMR_SIG_G;
		c1 = colour_space_bit ? `VEMR_SIG_U : `VEMR_SIG_B;
		c2 = colour_space_bit ? `VEMR_SIG_V : `VEMR_SIG_R;
		// Source order per nibble: A in low nibble up to F
		if (large_dac_select_bit)
			dac_src = {c2, c1, c0, `VEMR_SIG_CHROMA, `VEMR_SIG_LUMA,
				`VEMR_SIG_CVBS};
		else if (dac_switching_bit)
			dac_src = {`VEMR_SIG_CHROMA, `VEMR_SIG_LUMA, c0, c2, c1,
				`VEMR_SIG_CVBS};
		else
			dac_src = {`VEMR_SIG_CHROMA, `VEMR_SIG_LUMA,
				`VEMR_SIG_CVBS, c2, c1, c0};
	end
endmodule

// ==== logic/vemr_regs.v ====
// Mode register bank 0..2 of the video encoder, with datapath controls.
// Assumes a serial-bus front end delivers subaddress, data and strobes
// synchronous to clk (the pixel clock).
//
// Behaviour
// - Two-bit standard field selects NTSC, PAL BDGHI, PAL M or PAL N.
// - Luma filter select applies independent of the chosen standard.
// - Chroma filter field picks low-pass cutoff or CIF/QCIF filter.
// - Six power-down bits each switch off their own DAC.
// - Low-power bit halves current of powered large DACs only.
// - Low power keeps the set-resistor to output-current relation.
// - Third mode register is eight bits at subaddress 02H.
// - Colour-space bit picks YUV or RGB for the component DACs.
// - Large-DAC bit set gives composite, luma, chroma on A, B, C.
// - Switching bit moves outputs from SCART to EuroSCART layout; large-DAC bit wins if both set.
// - Pedestal bit adds NTSC setup; ignored when PAL selected.
// - EuroSCART: A composite, E/F luma/chroma, B/C/D components.
`timescale 1ns/1ps
`include "vemr_map.vh"
module vemr_regs (
	input wire clk,
	input wire nrst,
	input wire [4:0] register_subaddress,
	input wire [7:0] wr_data,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rd_data,
	output reg rd_hit,
	output reg [1:0] standard_select_field,
	output reg ntsc_enable,
	output reg [2:0] luma_filter_field,
	output reg [2:0] chroma_filter_field,
	output reg [5:0] dac_enable,
	output reg [5:0] dac_low_power,
	output reg pedestal_enable,
	output reg [23:0] dac_source
);
	reg [7:0] std_filt_q;
	reg [7:0] std_filt_d;
	reg [7:0] dac_pwr_q;
	reg [7:0] dac_pwr_d;
	reg [7:0] routing_q;
	reg [7:0] routing_d;
	reg sel_std_filt;
	reg sel_dac_pwr;
	reg sel_routing;
	reg [7:0] rd_d;
	reg hit_d;
	reg [1:0] std_d;
	reg ntsc_d;
	reg [2:0] luma_d;
	reg [2:0] chroma_d;
	reg [5:0] dac_en_d;
	reg [5:0] dac_lp_d;
	reg ped_d;
	reg [23:0] src_d;
	wire [23:0] route_w;

	// True when subaddress a selects register slot s
	function addr_match;
		input [4:0] a;
		input [4:0] s;
		begin
			addr_match = (a == s);
		end
	endfunction

	// Reserved top bit of the power register is never kept
	function [7:0] dac_pwr_clean;
		input [7:0] d;
		begin
			dac_pwr_clean = d & `VEMR_DAC_PWR_MASK;
		end
	endfunction

	function [1:0] std_of;
		input [7:0] r;
		begin
			std_of = r[`VEMR_STD_LSB +: 2];
		end
	endfunction

	function is_ntsc;
		input [1:0] s;
		begin
			is_ntsc = (s == `VEMR_STD_NTSC);
		end
	endfunction

	function [2:0] luma_of;
		input [7:0] r;
		begin
			luma_of = r[`VEMR_LUMA_LSB +: 3];
		end
	endfunction

	function [2:0] chroma_of;
		input [7:0] r;
		begin
			chroma_of = r[`VEMR_CHROMA_LSB +: 3];
		end
	endfunction

	// Power-down bits, DAC A in bit 0 up to DAC F
	function [5:0] pd_bits;
		input [7:0] r;
		begin
			pd_bits = r[`VEMR_PD_LSB +: 6];
		end
	endfunction

	// Low power reaches only large DACs A-C that are switched on
	function [5:0] low_power_mask;
		input [7:0] r;
		reg [5:0] dac_on;
		begin
			dac_on = ~pd_bits(r);
			low_power_mask = {3'h0,
				{3{r[`VEMR_LOW_POWER_BIT]}} & dac_on[2:0]};
		end
	endfunction

	function [7:0] read_mux;
		input [4:0] a;
		input [7:0] r0;
		input [7:0] r1;
		input [7:0] r2;
		begin
			case (a)
				`VEMR_ADDR_STD_FILT: read_mux = r0;
				`VEMR_ADDR_DAC_PWR: read_mux = dac_pwr_clean(r1);
				`VEMR_ADDR_ROUTING: read_mux = r2;
				default: read_mux = 8'h00;
			endcase
		end
	endfunction

	// Write strobe decoded per register slot
	always @*
	begin
		sel_std_filt = wr_stb &
			addr_match(register_subaddress, `VEMR_ADDR_STD_FILT);
		sel_dac_pwr = wr_stb &
			addr_match(register_subaddress, `VEMR_ADDR_DAC_PWR);
		sel_routing = wr_stb &
			addr_match(register_subaddress, `VEMR_ADDR_ROUTING);
	end

	// Next register values; other subaddresses leave all three alone
	always @*
	begin
		std_filt_d = std_filt_q;
		dac_pwr_d = dac_pwr_q;
		routing_d = routing_q;
		if (sel_std_filt)
		begin
			std_filt_d = wr_data;
		end
		if (sel_dac_pwr)
		begin
			dac_pwr_d = dac_pwr_clean(wr_data);
		end
		if (sel_routing)
		begin
			routing_d = wr_data;
		end
	end

	// Standard and filter register
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			std_filt_q <= `VEMR_RST_STD_FILT;
		end
		else
		begin
			std_filt_q <= std_filt_d;
		end
	end

	// DAC power register
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dac_pwr_q <= `VEMR_RST_DAC_PWR;
		end
		else
		begin
			dac_pwr_q <= dac_pwr_d;
		end
	end

	// Output routing register
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			routing_q <= `VEMR_RST_ROUTING;
		end
		else
		begin
			routing_q <= routing_d;
		end
	end

	// Read data follows the subaddress; sampled only on rd_stb
	always @*
	begin
		rd_d = read_mux(register_subaddress, std_filt_q, dac_pwr_q,
			routing_q);
		hit_d = (register_subaddress <= `VEMR_ADDR_ROUTING);
	end

	// Read answer holds until the next read strobe
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_data <= 8'h00;
			rd_hit <= 1'h0;
		end
		else if (rd_stb)
		begin
			rd_data <= rd_d;
			rd_hit <= hit_d;
		end
	end

	// Source per DAC from the three routing bits
	vemr_route u_route (
		.colour_space_bit(routing_q[`VEMR_COLOUR_SPACE_BIT]),
		.large_dac_select_bit(routing_q[`VEMR_LARGE_DAC_BIT]),
		.dac_switching_bit(routing_q[`VEMR_DAC_SWITCH_BIT]),
		.dac_src(route_w)
	);

	// Standard and filter controls follow register 0
	always @*
	begin
		std_d = std_of(std_filt_q);
		ntsc_d = is_ntsc(std_of(std_filt_q));
		luma_d = luma_of(std_filt_q);
		chroma_d = chroma_of(std_filt_q);
	end

	// DAC controls follow registers 1 and 2; pedestal also needs register 0
	always @*
	begin
		dac_en_d = ~pd_bits(dac_pwr_q);
		// Current scale is not touched by low power
		dac_lp_d = low_power_mask(dac_pwr_q);
		// Setup only for NTSC; every PAL variant ignores it
		ped_d = routing_q[`VEMR_PEDESTAL_BIT] &
			is_ntsc(std_of(std_filt_q));
		src_d = route_w;
	end

	// Standard and filter outputs, one clock after the register
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			standard_select_field <= `VEMR_STD_NTSC;
			ntsc_enable <= 1'h1;
			luma_filter_field <= 3'h0;
			chroma_filter_field <= 3'h0;
		end
		else
		begin
			standard_select_field <= std_d;
			ntsc_enable <= ntsc_d;
			luma_filter_field <= luma_d;
			chroma_filter_field <= chroma_d;
		end
	end

	// Per-DAC enable and low-power outputs
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dac_enable <= `VEMR_RST_DAC_EN;
			dac_low_power <= 6'h00;
		end
		else
		begin
			dac_enable <= dac_en_d;
			dac_low_power <= dac_lp_d;
		end
	end

	// Output assignment and pedestal outputs
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pedestal_enable <= 1'h0;
			dac_source <= 24'h000000;
		end
		else
		begin
			pedestal_enable <= ped_d;
			dac_source <= src_d;
		end
	end
endmodule

// ==== bench/vemr_host.sv ====
// Host model: one-byte register accesses by subaddress.
// Assumes the design samples the strobes on rising clk.
`timescale 1ns/1ps
module vemr_host (
	input wire clk,
	output logic [4:0] register_subaddress,
	output logic [7:0] wr_data,
	output logic wr_stb,
	output logic rd_stb
);
	initial {register_subaddress, wr_data, wr_stb, rd_stb} = 15'h0;
	task automatic acc(input bit w, input [4:0] a, input [7:0] d);
		@(posedge clk);
		register_subaddress <= a;
		wr_data <= (a == 5'h01) ? (d & 8'h7f) : d;
		wr_stb <= w;
		rd_stb <= !w;
		@(posedge clk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		wr_data <= ~wr_data;
	endtask
endmodule

// ==== bench/vemr_regs_assertions.sv ====
// Checker on the mode register bank ports.
// Assumes one clock domain and nrst active low.
`timescale 1ns/1ps
module vemr_regs_assertions (
	input wire clk,
	input wire nrst,
	input wire [4:0] register_subaddress,
	input wire [7:0] wr_data,
	input wire wr_stb,
	input wire rd_stb,
	input wire [7:0] rd_data,
	input wire rd_hit,
	input wire [1:0] standard_select_field,
	input wire ntsc_enable,
	input wire [5:0] dac_enable,
	input wire [5:0] dac_low_power,
	input wire pedestal_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_ntsc_flag: assert property (
		ntsc_enable == (standard_select_field == 2'h0)) else $error("ntsc");
	chk_ped_gate: assert property (
		pedestal_enable |-> ntsc_enable) else $error("pedestal");
	chk_small_lp: assert property (
		dac_low_power[5:3] == 3'h0) else $error("small lp");
	chk_lp_on: assert property (
		(dac_low_power[2:0] & ~dac_enable[2:0]) == 3'h0) else $error("lp");
	chk_rd_hold: assert property (
		!rd_stb |=> $stable(rd_data)) else $error("rd hold");
	chk_rd_miss: assert property (
		rd_stb && register_subaddress > 5'h02 |=> rd_data == 8'h00 && !rd_hit)
		else $error("rd miss");
	chk_std_lat: assert property (
		wr_stb && register_subaddress == 5'h00 |=> ##1
		standard_select_field == $past(wr_data[1:0], 2)) else $error("std");
	chk_pwr_lat: assert property (
		wr_stb && register_subaddress == 5'h01 |=> ##1
		dac_enable == ~$past(wr_data[5:0], 2)) else $error("pwr");
	cover property (rd_stb && register_subaddress == 5'h03);
	cover property (pedestal_enable);
	cover property (|dac_low_power);
endmodule
bind vemr_regs vemr_regs_assertions u_chk (.*);

// ==== bench/vemr_regs_tb.sv ====
// Bench: random host traffic against an integer register model.
// Assumes 20 MHz clk; outputs settle two edges after a write.
`timescale 1ns/1ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
 $display("CHECK FAILED %0t mismatch", $time); end end
module vemr_regs_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] sa;
	logic [7:0] wd, rd_data;
	logic ws, rs, rd_hit, ntsc, ped;
	logic [1:0] std;
	logic [2:0] luma, chroma;
	logic [5:0] en, lp;
	logic [23:0] src;
	int failures = 0;
	int n_compared = 0;
	int m[3];
	int a;
	int d;
	always #25 clk = ~clk;
	vemr_host u_vemr_host (.clk(clk), .register_subaddress(sa),
		.wr_data(wd), .wr_stb(ws), .rd_stb(rs));
	vemr_regs u_vemr_regs (.clk(clk), .nrst(nrst), .register_subaddress(sa),
		.wr_data(wd), .wr_stb(ws), .rd_stb(rs), .rd_data(rd_data),
		.rd_hit(rd_hit), .standard_select_field(std), .ntsc_enable(ntsc),
		.luma_filter_field(luma), .chroma_filter_field(chroma),
		.dac_enable(en), .dac_low_power(lp), .pedestal_enable(ped),
		.dac_source(src));
	function automatic [23:0] route(input [2:0] r);
		logic [23:0] t[8] = '{24'h210354, 24'h210876, 24'h354210, 24'h876210,
			24'h214350, 24'h216870, 24'h354210, 24'h876210};
		return t[r];
	endfunction
	task automatic check(input int ra);
		`CMP(rd_data, (ra < 3) ? m[ra][7:0] : 8'h00)
		`CMP(rd_hit, ra < 3)
		`CMP(std, m[0][1:0])
		`CMP(ntsc, m[0][1:0] == 0)
		`CMP(luma, m[0][4:2])
		`CMP(chroma, m[0][7:5])
		`CMP(en, ~m[1][5:0])
		`CMP(lp, {3'h0, {3{m[1][6]}} & ~m[1][2:0]})
		`CMP(ped, m[2][3] && m[0][1:0] == 0)
		`CMP(src, route(m[2][2:0]))
	endtask
	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h0f36ae47));
		m = '{0, 0, 0};
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		u_vemr_host.acc(0, 5'h00, 8'h00);
		#1;
		check(0);
		repeat (300)
		begin
			a = $urandom_range(3);
			d = $urandom_range(255);
			u_vemr_host.acc(1, a[4:0], d[7:0]);
			if (a < 3)
				m[a] = (a == 1) ? d & 8'h7f : d;
			u_vemr_host.acc(0, a[4:0], 8'h00);
			#1;
			check(a);
		end
		stop_test();
	end
	initial
	begin
		#2000000;
		failures++;
		stop_test();
	end
endmodule
